// [core/boot_consts.vh]
// Purpose: Constants for the tile reset, PLL set-up and boot loader.
// Assumes: 100 MHz system clock; flash read byte-wise over a simple port.
// Notes:   Offsets, positions, resets and the boot delay count live here.
// Summary of operation
// - Reset low holds device, enables pin pull-downs.
// - Boot starts 15-150 us after reset release.
// - Mode pins select PLL multiplier and feedback.
// - Tile clock from feedback, reference and output dividers.
// - Software may rewrite the PLL configuration register.
// - PLL clocks switch, tile and reference clock.
// - Default boot source is the embedded flash.
// - Security bit 5 selects one-time memory boot.
// - Image is length, program bytes, then CRC.
// - Length and CRC fields arrive low byte first.
// - Program written from RAM address zero, started there.
// - CRC covers length bytes then program bytes.
// - Reflected CRC-32, preset all ones, result inverted.
// - Secure boot starts at one-time memory address zero.
`ifndef BOOT_CONSTS_VH
`define BOOT_CONSTS_VH

`define CLK_MHZ            100
`define BOOT_DELAY_US      15
`define BOOT_DELAY_CYC     (`BOOT_DELAY_US * `CLK_MHZ)
`define SEC_BOOT_BIT       5
`define CRC_POLY           32'hEDB8_8320
`define CRC_PRESET         32'hFFFF_FFFF
`define CRC_SKIP_MARK      32'h0D15_AB1E
`define PLL_OD_BOOT        3'h1
`define PLL_R_BOOT         6'h00
`define PLL_F_MODE00       12'h09F
`define PLL_F_MODE11       12'h03F
`define PLL_F_MODE10       12'h01F
`define PLL_F_MODE01       12'h00F
`define PLL_MUL_MODE00     6'h28
`define PLL_MUL_MODE11     6'h10
`define PLL_MUL_MODE10     6'h08
`define PLL_MUL_MODE01     6'h04
`define REG_PLL_CFG        2'h0
`define REG_STATUS         2'h1
`define REG_SECURITY       2'h2
`define PLL_F_LSB          0
`define PLL_R_LSB          12
`define PLL_OD_LSB         18

`endif

// [core/crc32_byte.v]
// Purpose: One-byte step of the reflected CRC-32.
// Assumes: Combinational; caller holds the register.
// Notes:   Eight bit steps unrolled by a loop.
`timescale 1ns/1ps
`include "boot_consts.vh"
module crc32_byte
(
  // Input state and data
  input  wire [31:0] crc_in,
  input  wire [7:0]  data_in,
  // Next state
  output reg  [31:0] crc_out
);
  integer i;
  always @*
  begin
    crc_out = crc_in ^ {24'h00_0000, data_in};
    for (i = 0; i < 8; i = i + 1)
    begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ `CRC_POLY) : (crc_out >> 1);
    end
  end
endmodule

// [core/pll_mode_decode.v]
// Purpose: Boot PLL settings from the two mode pins.
// Assumes: Pins already synchronised.
// Notes:   Output divider and reference divider fixed at boot.
`timescale 1ns/1ps
`include "boot_consts.vh"
module pll_mode_decode
(
  // Mode pins
  input  wire [1:0]  mode,
  // Settings
  output reg  [11:0] fb_value,
  output reg  [5:0]  multiplier
);
  always @*
  begin
    case (mode)
      2'b00:
      begin
        fb_value   = `PLL_F_MODE00;
        multiplier = `PLL_MUL_MODE00;
      end
      2'b11:
      begin
        fb_value   = `PLL_F_MODE11;
        multiplier = `PLL_MUL_MODE11;
      end
      2'b10:
      begin
        fb_value   = `PLL_F_MODE10;
        multiplier = `PLL_MUL_MODE10;
      end
      default:
      begin
        fb_value   = `PLL_F_MODE01;
        multiplier = `PLL_MUL_MODE01;
      end
    endcase
  end
endmodule

// [core/boot_loader.v]
// Purpose: Reset sequencing, PLL set-up and boot image loading for a tile.
// Assumes: Flash answers a byte request with a valid pulse one or more cycles later.
// Notes:   The PLL itself is outside; this block supplies its F, R and OD values.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "boot_consts.vh"
module boot_loader
#(
  parameter DELAY_CYC = `BOOT_DELAY_CYC,
  parameter RAM_AW    = 16
)
(
  // Clock and reset
  input  wire              clk_sys,
  input  wire              reset,
  input  wire              rst_chip_n,
  // Straps
  input  wire [1:0]        mode_pins,
  input  wire [31:0]       security_word,
  // Register port
  input  wire [1:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // Flash byte reader
  output reg               flash_req,
  output reg  [23:0]       flash_addr,
  input  wire              flash_valid,
  input  wire [7:0]        flash_data,
  // One-time memory reader
  output reg               otp_req,
  output reg  [RAM_AW-1:0] otp_addr,
  input  wire              otp_valid,
  input  wire [31:0]       otp_data,
  // RAM write port
  output reg               ram_we,
  output reg  [RAM_AW-1:0] ram_addr,
  output reg  [31:0]       ram_wdata,
  // Core control and PLL
  output reg               core_run,
  output reg  [RAM_AW-1:0] core_start_addr,
  output reg               boot_error,
  output reg               gpio_pulldown,
  output reg  [11:0]       pll_f,
  output reg  [5:0]        pll_r,
  output reg  [2:0]        pll_output_divider
);
  localparam S_RESET = 7'b000_0001;
  localparam S_WAIT  = 7'b000_0010;
  localparam S_LEN   = 7'b000_0100;
  localparam S_PROG  = 7'b000_1000;
  localparam S_CRC   = 7'b001_0000;
  localparam S_OTP   = 7'b010_0000;
  localparam S_DONE  = 7'b100_0000;

  reg  [1:0]  rst_sync_q;
  reg  [1:0]  mode_s1_q;
  reg  [1:0]  mode_s2_q;
  reg  [6:0]  state_q;
  reg  [31:0] delay_q;
  reg  [31:0] len_q;
  reg  [31:0] word_q;
  reg  [31:0] words_q;
  reg  [1:0]  byte_q;
  reg  [31:0] crc_q;
  reg         pend_q;
  reg         otp_src_q;
  wire [31:0] crc_next;
  wire [11:0] boot_f;
  wire [31:0] word_next;

  crc32_byte u_crc
  (
    .crc_in  (crc_q),
    .data_in (flash_data),
    .crc_out (crc_next)
  );

  pll_mode_decode u_mode
  (
    .mode       (mode_s2_q),
    .fb_value   (boot_f),
    .multiplier ()
  );

  // Bytes shift in from the top so the first byte ends lowest.
  assign word_next = {flash_data, word_q[31:8]};

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rst_sync_q <= 2'b00;
      mode_s1_q  <= 2'b00;
      mode_s2_q  <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], rst_chip_n};
      mode_s1_q  <= mode_pins;
      mode_s2_q  <= mode_s1_q;
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q            <= S_RESET;
      delay_q            <= 32'h0000_0000;
      len_q              <= 32'h0000_0000;
      word_q             <= 32'h0000_0000;
      words_q            <= 32'h0000_0000;
      byte_q             <= 2'h0;
      crc_q              <= `CRC_PRESET;
      pend_q             <= 1'b0;
      otp_src_q          <= 1'b0;
      flash_req          <= 1'b0;
      flash_addr         <= 24'h00_0000;
      otp_req            <= 1'b0;
      otp_addr           <= {RAM_AW{1'b0}};
      ram_we             <= 1'b0;
      ram_addr           <= {RAM_AW{1'b0}};
      ram_wdata          <= 32'h0000_0000;
      core_run           <= 1'b0;
      core_start_addr    <= {RAM_AW{1'b0}};
      boot_error         <= 1'b0;
      gpio_pulldown      <= 1'b1;
      pll_f              <= `PLL_F_MODE00;
      pll_r              <= `PLL_R_BOOT;
      pll_output_divider <= `PLL_OD_BOOT;
    end
    else
    begin
      flash_req <= 1'b0;
      otp_req   <= 1'b0;
      ram_we    <= 1'b0;
      if (!rst_sync_q[1])
      begin
        // Chip reset pin low: hold everything and pull pins down.
        state_q       <= S_RESET;
        gpio_pulldown <= 1'b1;
        core_run      <= 1'b0;
        boot_error    <= 1'b0;
        pend_q        <= 1'b0;
        delay_q       <= 32'h0000_0000;
      end
      else if (reg_wr && reg_addr == `REG_PLL_CFG)
      begin
        pll_f              <= reg_wdata[`PLL_F_LSB +: 12];
        pll_r              <= reg_wdata[`PLL_R_LSB +: 6];
        pll_output_divider <= reg_wdata[`PLL_OD_LSB +: 3];
      end
      if (rst_sync_q[1])
      begin
        case (state_q)
          S_RESET:
          begin
            gpio_pulldown      <= 1'b0;
            // Straps are caught once the reset pin is released.
            pll_f              <= boot_f;
            pll_r              <= `PLL_R_BOOT;
            pll_output_divider <= `PLL_OD_BOOT;
            crc_q              <= `CRC_PRESET;
            byte_q             <= 2'h0;
            words_q            <= 32'h0000_0000;
            flash_addr         <= 24'h00_0000;
            otp_addr           <= {RAM_AW{1'b0}};
            ram_addr           <= {RAM_AW{1'b0}};
            otp_src_q          <= security_word[`SEC_BOOT_BIT];
            state_q            <= S_WAIT;
          end
          S_WAIT:
          begin
            delay_q <= delay_q + 32'h0000_0001;
            if (delay_q >= DELAY_CYC - 1)
            begin
              state_q <= otp_src_q ? S_OTP : S_LEN;
            end
          end
          S_LEN, S_PROG, S_CRC:
          begin
            if (!pend_q)
            begin
              flash_req <= 1'b1;
              pend_q    <= 1'b1;
            end
            else if (flash_valid)
            begin
              pend_q     <= 1'b0;
              flash_addr <= flash_addr + 24'h00_0001;
              word_q     <= word_next;
              byte_q     <= byte_q + 2'h1;
              if (state_q != S_CRC)
              begin
                crc_q <= crc_next;
              end
              if (byte_q == 2'h3)
              begin
                case (state_q)
                  S_LEN:
                  begin
                    len_q   <= word_next;
                    state_q <= (word_next == 32'h0000_0000) ? S_CRC : S_PROG;
                  end
                  S_PROG:
                  begin
                    ram_we    <= 1'b1;
                    ram_wdata <= word_next;
                    ram_addr  <= words_q[RAM_AW-1:0];
                    words_q   <= words_q + 32'h0000_0001;
                    if (words_q + 32'h0000_0001 == len_q)
                    begin
                      state_q <= S_CRC;
                    end
                  end
                  default:
                  begin
                    state_q <= S_DONE;
                    if (word_next == `CRC_SKIP_MARK || word_next == ~crc_q)
                    begin
                      core_run        <= 1'b1;
                      core_start_addr <= {RAM_AW{1'b0}};
                    end
                    else
                    begin
                      boot_error <= 1'b1;
                    end
                  end
                endcase
              end
            end
          end
          S_OTP:
          begin
            // The first 2048 one-time memory words are copied, then run from zero.
            if (!pend_q)
            begin
              otp_req <= 1'b1;
              pend_q  <= 1'b1;
            end
            else if (otp_valid)
            begin
              pend_q    <= 1'b0;
              ram_we    <= 1'b1;
              ram_wdata <= otp_data;
              ram_addr  <= otp_addr;
              otp_addr  <= otp_addr + {{(RAM_AW-1){1'b0}}, 1'b1};
              if (&otp_addr[10:0])
              begin
                state_q <= S_DONE;
              end
            end
          end
          S_DONE:
          begin
            state_q <= S_DONE;
            // The one-time memory image starts a cycle after its last copy, so no
            // RAM write overlaps the running program.
            if (otp_src_q)
            begin
              core_run        <= 1'b1;
              core_start_addr <= {RAM_AW{1'b0}};
            end
          end
          default:
          begin
            state_q <= S_RESET;
          end
        endcase
      end
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_PLL_CFG:
        begin
          reg_rdata <= {11'h000, pll_output_divider, pll_r, pll_f};
        end
        `REG_STATUS:
        begin
          reg_rdata <= {23'h00_0000, state_q, boot_error, core_run};
        end
        `REG_SECURITY:
        begin
          reg_rdata <= security_word;
        end
        default:
        begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// [verif/boot_loader_asserts.sv]
// Purpose: Concurrent checks on the boot loader ports.
// Assumes: Flash valid only ever answers a pending request.
// Notes:   Bound into every boot_loader instance.
`timescale 1ns/1ps
module boot_loader_asserts
#(
  parameter RAM_AW = 16
)
(
  // Clock and resets
  input logic              clk_sys,
  input logic              reset,
  input logic              rst_chip_n,
  // Inputs
  input logic [31:0]       security_word,
  input logic [1:0]        reg_addr,
  input logic [31:0]       reg_wdata,
  input logic              reg_wr,
  input logic              reg_rd,
  input logic              flash_valid,
  // Outputs
  input logic [31:0]       reg_rdata,
  input logic              flash_req,
  input logic [23:0]       flash_addr,
  input logic              ram_we,
  input logic              core_run,
  input logic [RAM_AW-1:0] core_start_addr,
  input logic              boot_error,
  input logic              gpio_pulldown,
  input logic [11:0]       pll_f,
  input logic [5:0]        pll_r,
  input logic [2:0]        pll_output_divider
);
  logic [31:0] wdata_q;
  always @(posedge clk_sys or posedge reset)
    if (reset)
      wdata_q <= 32'h0000_0000;
    else
      wdata_q <= reg_wdata;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_pull_low: assert property (!rst_chip_n [*5] |-> gpio_pulldown && !flash_req && !core_run)
    else $error("chip reset not holding");
  a_pll_write: assert property (reg_wr && reg_addr == 2'h0 && core_run && rst_chip_n
    |=> {pll_output_divider, pll_r, pll_f} == wdata_q[20:0]) else $error("pll write lost");
  a_rd_idle: assert property (!reg_rd || reg_addr == 2'h3 |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  a_run_err: assert property (boot_error |-> !core_run) else $error("ran with error");
  a_req_pulse: assert property (flash_req |=> !flash_req) else $error("long request");
  a_addr_step: assert property (flash_valid |=> flash_addr == $past(flash_addr) + 24'h1)
    else $error("flash address skip");
  a_start_zero: assert property ($rose(core_run) |-> core_start_addr == '0)
    else $error("start not zero");
  a_ram_before: assert property (ram_we |-> !core_run) else $error("write after start");
  a_flash_sec: assert property (flash_req |-> !security_word[5]) else $error("flash in secure");
endmodule
bind boot_loader boot_loader_asserts #(.RAM_AW(RAM_AW)) u_chk (.*);

// [verif/flash_model.sv]
// Purpose: Behavioural byte flash on the loader's read port.
// Assumes: One request outstanding at a time.
// Notes:   Answer delay set by the bench.
`timescale 1ns/1ps
module flash_model
(
  // Clock
  input  logic        clk_sys,
  // Byte port
  input  logic        flash_req,
  input  logic [23:0] flash_addr,
  output logic        flash_valid,
  output logic [7:0]  flash_data,
  // Answer delay in cycles
  input  logic [3:0]  lat
);
  logic [7:0] mem [0:255];
  logic [7:0] a;
  initial
  begin
    flash_valid = 0;
    flash_data = 8'h00;
  end
  // Idle data toggles so a stale byte never passes for a fresh one.
  always
  begin
    @(posedge clk_sys);
    if (flash_req)
    begin
      a = flash_addr[7:0];
      repeat (lat) @(posedge clk_sys);
      flash_valid <= 1;
      flash_data <= mem[a];
      @(posedge clk_sys);
      flash_valid <= 0;
      flash_data <= ~mem[a];
    end
    else
      flash_data <= ~flash_data;
  end
endmodule

// [verif/boot_loader_tb_top.sv]
// Purpose: Self-checking bench for the boot loader.
// Assumes: Boot delay shortened to 10 cycles.
// Notes:   Random images, lengths and flash delays from a fixed seed.
`timescale 1ns/1ps
`include "boot_consts.vh"
module boot_loader_tb_top;
  logic        clk_sys = 0, reset = 1, rst_chip_n = 0;
  logic        reg_wr = 0, reg_rd = 0, otp_valid = 0;
  logic [1:0]  mode_pins = 0, reg_addr = 0;
  logic [31:0] security_word = 0, reg_wdata = 0, otp_data = 0;
  logic [31:0] reg_rdata, ram_wdata, w, r;
  logic        flash_req, flash_valid, otp_req, ram_we;
  logic        core_run, boot_error, gpio_pulldown;
  logic [23:0] flash_addr;
  logic [7:0]  flash_data;
  logic [15:0] otp_addr, ram_addr, core_start_addr;
  logic [11:0] pll_f;
  logic [5:0]  pll_r;
  logic [2:0]  pll_output_divider;
  logic [3:0]  lat = 0;
  logic [31:0] seed = 32'hce20_9d69;
  logic [31:0] ram [0:15];
  logic [31:0] img [0:15];
  logic [11:0] fx [0:3] = '{12'h09F, 12'h00F, 12'h01F, 12'h03F};
  int          n_fail = 0, n_checks = 0;
  boot_loader #(.DELAY_CYC(10)) dut (.*);
  flash_model u_flash (.*);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    otp_valid <= otp_req;
    otp_data <= otp_req ? {16'h5a5a, otp_addr} : ~otp_data;
    if (ram_we && ram_addr < 16)
      ram[ram_addr[3:0]] <= ram_wdata;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] b);
    c ^= {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [1:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [1:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  // kind 0 good CRC, 1 skip marker, 2 corrupted CRC.
  task automatic boot(int len, logic [1:0] m, int kind);
    logic [31:0] c;
    int t;
    c = 32'hffff_ffff;
    for (int i = 0; i <= len + 1; i++)
    begin
      w = i == 0 ? len : rnd();
      if (i == len + 1)
        w = kind == 1 ? `CRC_SKIP_MARK : ~c ^ (kind == 2);
      for (int b = 0; b < 4; b++)
      begin
        u_flash.mem[4*i+b] = w[8*b+:8];
        c = crc_b(c, w[8*b+:8]);
      end
      img[i] = w;
    end
    for (int i = 0; i < 16; i++)
      ram[i] = 32'h0;
    mode_pins <= m;
    lat <= 4'(rnd() % 4);
    rst_chip_n <= 0;
    // Six edges low so the hold state has settled through the synchroniser.
    repeat (6) @(posedge clk_sys);
    chk(gpio_pulldown, 1);
    rst_chip_n <= 1;
    t = 0;
    while (!flash_req && !otp_req && t < 50)
    begin
      @(posedge clk_sys);
      #1 t++;
    end
    chk(t >= 13 && t < 16, 1);
    while (!core_run && !boot_error && t < 9000)
    begin
      @(posedge clk_sys);
      #1 t++;
    end
    @(posedge clk_sys);
    chk(core_run, kind != 2);
    chk(boot_error, kind == 2);
    chk(gpio_pulldown, 0);
    chk(core_start_addr, 0);
    chk(pll_f, fx[m]);
    chk({pll_r, pll_output_divider}, 9'h001);
    if (!security_word[5])
      chk(flash_addr, 8 + 4 * len);
    for (int i = 0; i < len && kind != 2 && !security_word[5]; i++)
      chk(ram[i], img[i+1]);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    boot(0, 2'b00, 0);
    boot(3, 2'b01, 1);
    boot(5, 2'b10, 2);
    for (int k = 0; k < 4; k++)
      boot(int'(rnd() % 9), 2'(k), 0);
    repeat (4)
    begin
      w = rnd();
      wr(2'h0, w);
      rd(2'h0, r);
      chk({pll_output_divider, pll_r, pll_f}, w[20:0]);
      chk(r[20:0], w[20:0]);
    end
    rd(2'h3, r);
    chk(r, 32'h0);
    rd(2'h1, r);
    chk(r, {23'h0, 7'b100_0000, 2'b01});
    security_word <= 32'h0000_0020;
    boot(2, 2'b11, 0);
    for (int i = 0; i < 4; i++)
      chk(ram[i], {16'h5a5a, 16'(i)});
    rd(2'h2, r);
    chk(r, 32'h0000_0020);
    end_sim();
  end
  initial
  begin
    #600_000;
    n_fail++;
    end_sim();
  end
endmodule
